// ---- t16oc_cfg.svh ----
// Constants for the 16-bit timer with overflow flag and two capture/compare channels.
`ifndef T16OC_CFG_SVH
`define T16OC_CFG_SVH
`define T16OC_CNT_W 16
`define T16OC_CNT_MAX 16'hffff
`define T16OC_CNT_ZERO 16'h0000
`define T16OC_CNT_ONE 16'h0001
`define T16OC_RST_CC 16'h0000
`define T16OC_MODE_W 2
`define T16OC_SYNC_W 3
`define T16OC_SYNC_CLK 0
`define T16OC_SYNC_TRIG_FIRST 1
`define T16OC_SYNC_TRIG_SECOND 2
`define T16OC_NUM_CH 2
`endif

// ---- t16oc_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
`default_nettype none
module t16oc_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic lvl_ff;
            logic agree;
            logic nxt_lvl;
            // The first stage feeds only the second; the filter looks at stages two and three.
            assign agree = (s2_ff == s3_ff);
            assign nxt_lvl = agree ? s3_ff : lvl_ff;
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    lvl_ff <= 1'b0;
                end else begin
                    s1_ff <= pin_in[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    lvl_ff <= nxt_lvl;
                end
            end
            assign level_out[i] = lvl_ff;
            assign rise_out[i] = nxt_lvl & ~lvl_ff;
            assign fall_out[i] = ~nxt_lvl & lvl_ff;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- t16oc_pkg.sv ----
// Types shared by the timer modules.
package t16oc_pkg;
    // Order matters: positions match the two-bit operating-mode field.
    typedef enum logic [1:0] {
        T16OC_STOP,
        T16OC_TRIG_CLEAR,
        T16OC_FREE_RUN,
        T16OC_MATCH_CLEAR
    } t16oc_mode_t;
endpackage

// ---- t16oc_timer.sv ----
// 16-bit timer with overflow flag and two capture/compare channels.
`timescale 1ns/1ps
`default_nettype none
`include "t16oc_cfg.svh"
module t16oc_timer
    import t16oc_pkg::*;
#(
    parameter int CNT_W = `T16OC_CNT_W
) (
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    input wire logic COUNT_CLK_IN,
    input wire logic TRIGGER_INPUT_FIRST_IN,
    input wire logic TRIGGER_INPUT_SECOND_IN,
    input wire logic OP_MODE_FIELD_HIGH_IN,
    input wire logic OP_MODE_FIELD_LOW_IN,
    input wire logic CAPTURE_SEL_FIRST_IN,
    input wire logic CAPTURE_SEL_SECOND_IN,
    input wire logic CC_WR_FIRST_IN,
    input wire logic CC_WR_SECOND_IN,
    input wire logic [CNT_W-1:0] CC_WR_DATA_IN,
    input wire logic CC_RD_FIRST_IN,
    input wire logic CC_RD_SECOND_IN,
    output logic [CNT_W-1:0] CC_RD_DATA_OUT,
    output logic CC_RD_UNDEFINED_OUT,
    input wire logic COUNT_RD_IN,
    output logic [CNT_W-1:0] COUNT_RD_DATA_OUT,
    output logic [CNT_W-1:0] COUNT_VALUE_OUT,
    input wire logic OVERFLOW_CLR_IN,
    output logic OVERFLOW_FLAG_OUT,
    output logic CAPTURE_IRQ_FIRST_OUT,
    output logic CAPTURE_IRQ_SECOND_OUT
);
    localparam int NCH = `T16OC_NUM_CH;
    // Constants are cut to the counter width, so a narrower counter still wraps at all-ones.
    // The cut only works for widths up to sixteen bits; wider counters need wider constants.
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(`T16OC_CNT_MAX);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(`T16OC_CNT_ZERO);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(`T16OC_CNT_ONE);
    localparam logic [CNT_W-1:0] RST_CC = CNT_W'(`T16OC_RST_CC);

    logic [`T16OC_SYNC_W-1:0] sync_lvl;
    logic [`T16OC_SYNC_W-1:0] sync_rise;
    logic [`T16OC_SYNC_W-1:0] sync_fall;

    t16oc_pin_sync #(
        .WIDTH(`T16OC_SYNC_W)
    ) u_sync (
        .clk_in(CLOCK_IN),
        .arst_n_in(ARST_N_IN),
        .pin_in({TRIGGER_INPUT_SECOND_IN, TRIGGER_INPUT_FIRST_IN, COUNT_CLK_IN}),
        .level_out(sync_lvl),
        .rise_out(sync_rise),
        .fall_out(sync_fall)
    );

    t16oc_mode_t mode;
    logic running;
    logic cclk_rise;
    logic cclk_fall;
    logic advance;
    logic wrap;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic clr_pend_ff;
    logic nxt_clr_pend;
    logic wrap_win_ff;
    logic nxt_wrap_win;
    logic ovf_ff;
    logic nxt_ovf;
    logic [CNT_W-1:0] cc_ff [NCH];
    logic [NCH-1:0] trig_rise;
    logic [NCH-1:0] cap_sel;
    logic [NCH-1:0] cc_wr;
    logic [NCH-1:0] cc_rd;
    logic [NCH-1:0] latch;
    logic [NCH-1:0] irq_ff;
    logic [CNT_W-1:0] rd_data_ff;
    logic rd_undef_ff;
    logic [CNT_W-1:0] cnt_rd_ff;

    assign mode = t16oc_mode_t'({OP_MODE_FIELD_HIGH_IN, OP_MODE_FIELD_LOW_IN});
    assign running = (mode != T16OC_STOP);
    assign cclk_rise = sync_rise[`T16OC_SYNC_CLK];
    assign cclk_fall = sync_fall[`T16OC_SYNC_CLK];
    assign advance = running & cclk_rise;
    assign trig_rise = {sync_rise[`T16OC_SYNC_TRIG_SECOND], sync_rise[`T16OC_SYNC_TRIG_FIRST]};
    assign cap_sel = {CAPTURE_SEL_SECOND_IN, CAPTURE_SEL_FIRST_IN};
    assign cc_wr = {CC_WR_SECOND_IN, CC_WR_FIRST_IN};
    assign cc_rd = {CC_RD_SECOND_IN, CC_RD_FIRST_IN};

    // A first-trigger edge in the clear-and-start mode takes effect at the next count clock.
    assign nxt_clr_pend = (mode == T16OC_TRIG_CLEAR) &
        ((clr_pend_ff & ~advance) | trig_rise[0]);

    // Stop holds the counter at zero, so leaving stop starts cleanly from 0000H.
    assign nxt_cnt = !running ? CNT_ZERO :
        !advance ? cnt_ff :
        (clr_pend_ff | ((mode == T16OC_MATCH_CLEAR) && (cnt_ff == cc_ff[0]))) ?
        CNT_ZERO : CNT_W'(cnt_ff + CNT_ONE);

    // With the first register at FFFFH the match clear and the wrap coincide.
    assign wrap = advance & (cnt_ff == CNT_MAX);
    assign nxt_wrap_win = wrap | (wrap_win_ff & ~advance & running);
    assign nxt_ovf = wrap | wrap_win_ff | (ovf_ff & ~OVERFLOW_CLR_IN);

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cnt_ff <= CNT_ZERO;
            clr_pend_ff <= 1'b0;
            wrap_win_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            clr_pend_ff <= nxt_clr_pend;
            wrap_win_ff <= nxt_wrap_win;
            ovf_ff <= nxt_ovf;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
            logic pend_ff;
            logic arm_ff;
            logic nxt_pend;
            logic nxt_arm;
            logic [CNT_W-1:0] nxt_cc;
            // A trigger is held until the count clock falls, then the count is latched.
            assign latch[ch] = pend_ff & cclk_fall;
            assign nxt_pend = (running & cap_sel[ch] & trig_rise[ch]) | (pend_ff & ~cclk_fall);
            assign nxt_arm = latch[ch] | (arm_ff & ~cclk_rise);
            // The capture has priority over both a read and a write in the same cycle.
            assign nxt_cc = latch[ch] ? cnt_ff :
                (cc_wr[ch] & ~cap_sel[ch]) ? CC_WR_DATA_IN : cc_ff[ch];
            always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    pend_ff <= 1'b0;
                    arm_ff <= 1'b0;
                    irq_ff[ch] <= 1'b0;
                    cc_ff[ch] <= RST_CC;
                end else begin
                    pend_ff <= nxt_pend;
                    arm_ff <= nxt_arm;
                    irq_ff[ch] <= arm_ff & cclk_rise;
                    cc_ff[ch] <= nxt_cc;
                end
            end
        end
    endgenerate

    logic rd_collide;
    logic [CNT_W-1:0] nxt_rd_data;
    // A read that meets a capture returns the pre-capture value, flagged as undefined.
    assign rd_collide = |(cc_rd & latch & cap_sel);
    assign nxt_rd_data = cc_rd[1] ? cc_ff[1] : cc_rd[0] ? cc_ff[0] : rd_data_ff;

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rd_data_ff <= CNT_ZERO;
            rd_undef_ff <= 1'b0;
            cnt_rd_ff <= CNT_ZERO;
        end else begin
            rd_data_ff <= nxt_rd_data;
            rd_undef_ff <= rd_collide;
            cnt_rd_ff <= COUNT_RD_IN ? cnt_ff : cnt_rd_ff;
        end
    end

    assign CC_RD_DATA_OUT = rd_data_ff;
    assign CC_RD_UNDEFINED_OUT = rd_undef_ff;
    assign COUNT_RD_DATA_OUT = cnt_rd_ff;
    assign COUNT_VALUE_OUT = cnt_ff;
    assign OVERFLOW_FLAG_OUT = ovf_ff;
    assign CAPTURE_IRQ_FIRST_OUT = irq_ff[0];
    assign CAPTURE_IRQ_SECOND_OUT = irq_ff[1];

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!ARST_N_IN);

    ovf_on_wrap_a: assert property (
        (advance && cnt_ff == CNT_MAX) |=> (ovf_ff && cnt_ff == CNT_ZERO))
        else $error("overflow flag not set on counter wrap");
    clear_ignored_a: assert property (
        (wrap_win_ff && OVERFLOW_CLR_IN) |=> ovf_ff)
        else $error("overflow clear took effect before the count reached one");
    ovf_sticky_a: assert property (
        (ovf_ff && !OVERFLOW_CLR_IN) |=> ovf_ff)
        else $error("overflow flag dropped without a clear");
    ovf_clear_a: assert property (
        (ovf_ff && OVERFLOW_CLR_IN && !wrap && !wrap_win_ff) |=> !ovf_ff)
        else $error("overflow clear ignored outside the wrap window");
    capture_wins_a: assert property (
        (latch[1] && cc_rd[1] && cap_sel[1]) |=> (cc_ff[1] == $past(cnt_ff) && rd_undef_ff))
        else $error("read blocked a capture or was not flagged");
    count_read_clean_a: assert property (
        (COUNT_RD_IN && !latch[1] && !cc_wr[1]) |=> $stable(cc_ff[1]))
        else $error("counter read disturbed the second register");
    count_read_value_a: assert property (
        COUNT_RD_IN |=> (cnt_rd_ff == $past(cnt_ff)))
        else $error("counter read returned a wrong value");
    irq_after_rise_a: assert property (
        (g_ch[1].arm_ff && cclk_rise) |=> irq_ff[1])
        else $error("capture interrupt not raised on the next rise");
    irq_one_pulse_a: assert property (
        irq_ff[1] |=> !irq_ff[1])
        else $error("capture interrupt longer than one cycle");
    irq_cause_a: assert property (
        $rose(irq_ff[0]) |-> $past(cclk_rise))
        else $error("capture interrupt not on a count clock rise");
    stop_holds_a: assert property (
        (!running) |=> (cnt_ff == CNT_ZERO))
        else $error("counter moved in stop mode");
endmodule
`default_nettype wire

// ---- test_t16oc_timer.sv ----
// Self-checking testbench for the timer's overflow flag and capture behaviour.
`timescale 1ns/1ps
`default_nettype none
module test_t16oc_timer;
    import t16oc_pkg::*;
    // A narrow counter keeps the run to a few thousand cycles before it wraps.
    localparam int W = 8;
    logic clk, rst_n, cclk, trg0, trg1, mh, ml, sel0, sel1, wr0, wr1, rd0, rd1, crd, oclr;
    logic [W-1:0] wdata, rdata, cdata, cval, cap;
    logic undef, ovf, irq0, irq1;
    int errors = 0;
    int cmp_count = 0;
    int exp_cnt = 0;
    int seen = 0;
    int n_irq = 0;
    t16oc_timer #(.CNT_W(W)) dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n), .COUNT_CLK_IN(cclk),
        .TRIGGER_INPUT_FIRST_IN(trg0), .TRIGGER_INPUT_SECOND_IN(trg1),
        .OP_MODE_FIELD_HIGH_IN(mh), .OP_MODE_FIELD_LOW_IN(ml),
        .CAPTURE_SEL_FIRST_IN(sel0), .CAPTURE_SEL_SECOND_IN(sel1),
        .CC_WR_FIRST_IN(wr0), .CC_WR_SECOND_IN(wr1), .CC_WR_DATA_IN(wdata),
        .CC_RD_FIRST_IN(rd0), .CC_RD_SECOND_IN(rd1), .CC_RD_DATA_OUT(rdata),
        .CC_RD_UNDEFINED_OUT(undef), .COUNT_RD_IN(crd), .COUNT_RD_DATA_OUT(cdata),
        .COUNT_VALUE_OUT(cval), .OVERFLOW_CLR_IN(oclr), .OVERFLOW_FLAG_OUT(ovf),
        .CAPTURE_IRQ_FIRST_OUT(irq0), .CAPTURE_IRQ_SECOND_OUT(irq1));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One full count-clock period; each level is held past the synchroniser latency.
    task automatic step_cc();
        cclk = 1'b1;
        tick(6);
        cclk = 1'b0;
        tick(6);
    endtask
    task automatic t_start();
        repeat (3) step_cc();
        check(cval === 8'h00, "counter moved in stop mode");
        {mh, ml} = 2'b10;
        tick(1);
        repeat (3) step_cc();
        exp_cnt = 3;
        check(cval === W'(exp_cnt), "counter did not start");
    endtask
    task automatic t_capture();
        sel1 = 1'b1;
        trg1 = 1'b1;
        tick(6);
        cclk = 1'b1;
        tick(6);
        exp_cnt++;
        cclk = 1'b0;
        rd1 = 1'b1;
        repeat (8) begin
            tick(1);
            seen += int'(undef === 1'b1);
            n_irq += int'(irq1 === 1'b1);
        end
        rd1 = 1'b0;
        tick(1);
        check(seen > 0, "collision read not flagged undefined");
        check(n_irq == 0, "capture irq before count clock rise");
        rd1 = 1'b1;
        tick(1);
        rd1 = 1'b0;
        tick(1);
        cap = rdata;
        check(cap === W'(exp_cnt), "capture lost against read");
        cclk = 1'b1;
        repeat (6) begin
            tick(1);
            n_irq += int'(irq1 === 1'b1);
        end
        exp_cnt++;
        check(n_irq == 1, "capture irq not one pulse after rise");
        trg1 = 1'b0;
        crd = 1'b1;
        tick(1);
        crd = 1'b0;
        tick(1);
        check(cdata === W'(exp_cnt), "counter read value");
        cclk = 1'b0;
        tick(6);
        rd1 = 1'b1;
        tick(1);
        rd1 = 1'b0;
        tick(1);
        check(rdata === cap, "counter read loaded second register");
    endtask
    task automatic t_overflow();
        wdata = {W{1'b1}};
        wr0 = 1'b1;
        tick(1);
        wr0 = 1'b0;
        {mh, ml} = 2'b11;
        while (exp_cnt < (1 << W) - 1) begin
            step_cc();
            exp_cnt++;
        end
        check(ovf === 1'b0, "flag set before wrap");
        // The clear is held across the wrap so that the two coincide.
        oclr = 1'b1;
        cclk = 1'b1;
        tick(6);
        oclr = 1'b0;
        tick(1);
        check(ovf === 1'b1 && cval === 8'h00, "flag lost at wrap");
        cclk = 1'b0;
        tick(6);
        oclr = 1'b1;
        tick(1);
        oclr = 1'b0;
        tick(2);
        check(ovf === 1'b1, "clear took effect before next count");
        cclk = 1'b1;
        tick(6);
        check(ovf === 1'b1 && cval === 8'h01, "flag did not hold");
        oclr = 1'b1;
        tick(1);
        oclr = 1'b0;
        tick(1);
        check(ovf === 1'b0, "clear ignored outside wrap window");
    endtask
    // Clear-on-trigger mode with the first channel capturing; the count clock is high here.
    task automatic t_trig_clear();
        int n_irq0;
        n_irq0 = 0;
        {mh, ml} = 2'b01;
        sel0 = 1'b1;
        trg0 = 1'b1;
        tick(6);
        cclk = 1'b0;
        tick(6);
        cclk = 1'b1;
        repeat (6) begin
            tick(1);
            n_irq0 += int'(irq0 === 1'b1);
        end
        check(cval === 8'h00, "trigger edge did not clear the counter");
        check(n_irq0 == 1, "first capture irq not one pulse");
        rd0 = 1'b1;
        tick(1);
        rd0 = 1'b0;
        tick(1);
        check(rdata === 8'h01 && undef === 1'b0, "first register capture value");
        trg0 = 1'b0;
        tick(1);
    endtask
    initial begin
        #200us;
        errors++;
        end_of_test();
    end
    initial begin
        {rst_n, cclk, trg0, trg1, mh, ml, sel0, sel1, wr0, wr1, rd0, rd1, crd, oclr} = '0;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick(1);
        check(ovf === 1'b0 && cval === 8'h00 && irq1 === 1'b0, "reset outputs");
        t_start();
        t_capture();
        t_overflow();
        t_trig_clear();
        end_of_test();
    end
endmodule
`default_nettype wire
